/* hci_asserts.sv */
// Pin-level assertions for the host control port.
// Assumes binding into hci_top; pins cross two sync flops.
`timescale 1ns/100ps
`default_nettype none
module hci_asserts #(parameter int NSRC = 16) (
  // Clock, resets and host pins
  input wire logic            core_clk,
  input wire logic            sys_rst,
  input wire logic            hw_rst_n,
  input wire logic            host_sel,
  input wire logic            cs_n,
  input wire logic            data_strobe_n,
  input wire logic            sclk,
  input wire logic            out_edge_select,
  input wire logic [NSRC-1:0] irq_src,
  // Device outputs
  input wire logic            data_oe,
  input wire logic            serial_out,
  input wire logic            serial_out_oe,
  input wire logic            irq_out,
  input wire logic            irq_oe,
  input wire logic            line_drv_hiz
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Low run of the reset pin, saturating so it never wraps
  logic [3:0] low_q;
  always_ff @(posedge core_clk) begin
    if (hw_rst_n)
      low_q <= 4'h0;
    else if (low_q != 4'hf)
      low_q <= low_q + 4'h1;
  end
  sequence cs_idle_s; cs_n [*4]; endsequence
  sequence quiet_s; (irq_src == '0 && cs_n && hw_rst_n) [*6]; endsequence
  sequence hw_long_s; !hw_rst_n [*8] ##1 !hw_rst_n [*4]; endsequence
  // Serial output may only move after an edge of the chosen level
  property shift_p(logic lvl);
    serial_out_oe && $past(serial_out_oe) && $changed(serial_out) &&
      out_edge_select != lvl |-> $past(sclk, 2) == lvl && $past(sclk, 3) == lvl;
  endproperty
  rst_out_a: assert property (disable iff (1'b0) sys_rst |=>
    line_drv_hiz && !data_oe && !serial_out_oe && !irq_oe)
    else $error("outputs not in reset state");
  rd_cause_a: assert property ($rose(data_oe) |->
    $past(host_sel && !cs_n && !data_strobe_n, 3)) else $error("bus driven early");
  oe_release_a: assert property (cs_idle_s |-> !data_oe)
    else $error("bus not released");
  ser_oe_a: assert property ($rose(serial_out_oe) |->
    $past(!host_sel && !cs_n, 3)) else $error("serial out driven early");
  ser_rise_a: assert property (shift_p(1'b1))
    else $error("serial out moved off rising edge");
  ser_fall_a: assert property (shift_p(1'b0))
    else $error("serial out moved off falling edge");
  hw_filter_a: assert property ($rose(line_drv_hiz) && !$past(sys_rst) |->
    $past(low_q, 3) >= 4'h6) else $error("short reset pulse taken");
  hw_long_a: assert property (hw_long_s |-> line_drv_hiz)
    else $error("long reset pulse missed");
  irq_quiet_a: assert property (quiet_s |=>
    $stable(irq_out) && $stable(irq_oe)) else $error("irq pin moved alone");
endmodule
`default_nettype wire

/* hci_host_model.sv */
// Host controller model driving the control port pins.
// Assumes the bench calls its tasks; paced by core_clk.
`timescale 1ns/100ps
`default_nettype none
module hci_host_model (
  // Pacing clock and device outputs
  input  wire logic       core_clk,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  input  wire logic       serial_out,
  input  wire logic       serial_out_oe,
  // Pins toward the device
  output var logic        host_sel,
  output var logic        bus_style_select,
  output var logic        cs_n,
  output var logic  [7:0] addr,
  output var logic  [7:0] data_in,
  output var logic        data_strobe_n,
  output var logic        serial_in,
  output var logic        sclk,
  output var logic        out_edge_select
);
  // Deselected at start; shift clock parked low between frames
  initial begin
    {host_sel, bus_style_select, cs_n, data_strobe_n, serial_in} = 5'h1f;
    {addr, data_in, sclk, out_edge_select} = 18'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One parallel byte; chip select wraps the strobe on both sides
  task automatic par_acc(input logic sty, input logic wr, input logic [7:0] a,
                         input logic [7:0] wd, output logic [7:0] rd);
    host_sel <= 1'b1;
    bus_style_select <= sty;
    serial_in <= sty | ~wr;
    addr <= a;
    data_in <= wd;
    tick(4);
    cs_n <= 1'b0;
    tick(4);
    if (sty && wr) serial_in <= 1'b0;
    else data_strobe_n <= 1'b0;
    tick(6);
    rd = data_oe ? data_out : 8'hzz;
    if (sty && wr) serial_in <= 1'b1;
    else data_strobe_n <= 1'b1;
    tick(4);
    cs_n <= 1'b1;
    serial_in <= 1'b1;
    data_in <= ~wd;
    tick(6);
  endtask
  // One serial frame: read flag, address, data, MSB first
  task automatic ser_acc(input logic oes, input logic rdf, input logic [7:0] a,
                         input logic [7:0] wd, output logic [7:0] rd);
    logic [16:0] fr;
    fr = {rdf, a, wd};
    rd = 8'h00;
    host_sel <= 1'b0;
    out_edge_select <= oes;
    tick(4);
    cs_n <= 1'b0;
    for (int i = 0; i < 17; i++) begin
      serial_in <= fr[16-i];
      tick(4);
      if (i > 8 && !oes) rd[16-i] = serial_out_oe ? serial_out : 1'bx;
      sclk <= 1'b1;
      tick(4);
      if (i > 8 && oes) rd[16-i] = serial_out_oe ? serial_out : 1'bx;
      sclk <= 1'b0;
    end
    tick(4);
    cs_n <= 1'b1;
    serial_in <= ~fr[0];
    tick(6);
  endtask
endmodule
`default_nettype wire

/* hci_params.svh */
// Constants for the host control port: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the port's source files.
`ifndef HCI_PARAMS_SVH
`define HCI_PARAMS_SVH

// Register offsets on the 8-bit address bus
`define HCI_OFS_IRQ_MASK_LO   8'h11
`define HCI_OFS_IRQ_MASK_HI   8'h12
`define HCI_OFS_IRQ_STAT_LO   8'h16
`define HCI_OFS_IRQ_STAT_HI   8'h17
`define HCI_OFS_GLOBAL_CFG    8'h40
`define HCI_OFS_CHAN_IRQ      8'h80

// Global configuration fields
`define HCI_GCF_PIN_LSB       0
`define HCI_GCF_PIN_MSB       1
`define HCI_GCF_GMASK_BIT     2

// Interrupt pin styles in the two-bit field
`define HCI_PIN_OD_LOW        2'h0
`define HCI_PIN_PP_LOW        2'h1
`define HCI_PIN_PP_HIGH       2'h2

// Reset values
`define HCI_RST_IRQ_MASK      8'hff
`define HCI_RST_GLOBAL_CFG    8'h04

// Serial frame: read flag plus address, then one data byte
`define HCI_SER_CMD_LAST      5'h08
`define HCI_SER_DATA_LAST     5'h07

// Hardware reset pin filter
`define HCI_CLK_MHZ           50
`define HCI_RST_MIN_NS        100
`define HCI_RST_MIN_CYC  ((`HCI_RST_MIN_NS * `HCI_CLK_MHZ + 999) / 1000)

`endif

/* hci_pkg.sv */
// Types shared by the host control port.
// Assumes nothing beyond a SystemVerilog compiler.
package hci_pkg;

  // Serial frame phases
  typedef enum logic [1:0] {
    HCI_SER_CMD,
    HCI_SER_DATA,
    HCI_SER_DONE
  } hci_ser_state_t;

endpackage

/* hci_sync.sv */
// Two-flop synchroniser for a bundle of independent pin levels.
// Assumes each bit is a slow level; no bus coherence is promised.
`timescale 1ns/100ps
`default_nettype none

module hci_sync #(
  parameter int          W       = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // Asynchronous levels in, synchronous levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          meta_q[i]   <= RST_VAL[i];
          sync_out[i] <= RST_VAL[i];
        end else begin
          meta_q[i]   <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* hci_top.sv */
// Host control port: serial or parallel register access, interrupt pin.
// Assumes pins are asynchronous to core_clk; irq_src is core_clk logic.
`timescale 1ns/100ps
`default_nettype none
`include "hci_params.svh"

// Notes on behaviour
// - Style input low selects strobe-plus-direction, high selects split strobes.
// - Serial input is sampled on each rising shift clock edge.
// - Serial output changes on rising edge if edge select low, else falling.
// - Strobe-direction write captures the data bus under the data strobe.
// - Strobe-direction read drives register contents during the data strobe.
// - Read strobe low starts a read; device drives register data.
// - Write strobe low starts a write; device captures the data bus.
// - All interrupt sources combine onto one request output.
// - Global mask bit set blocks every source from the request output.
// - Each source has its own mask bit in two mask registers.
// - Status shown in per-channel summary byte and two status registers.
// - Two-bit field picks push-pull high, push-pull low or open-drain low.
// - Reset pin low longer than 100 ns resets the device.
// - Reset tri-states line drivers, clears flops, loads register defaults.
// - Parallel access selects the register with an 8-bit address.
// - Port select high picks parallel, low picks serial interface.
module hci_top #(
  parameter int NSRC = 16,
  parameter int NCH  = 4
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       hw_rst_n,
  // Interface selection pins
  input  wire logic       host_sel,
  input  wire logic       bus_style_select,
  input  wire logic       cs_n,
  // Parallel bus
  input  wire logic [7:0] addr,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  input  wire logic       data_strobe_n,
  // Serial in, doubling as direction or write strobe in parallel mode
  input  wire logic       serial_in,
  // Serial port
  input  wire logic       sclk,
  input  wire logic       out_edge_select,
  output logic            serial_out,
  output logic            serial_out_oe,
  // Interrupt sources and request pin
  input  wire logic [NSRC-1:0] irq_src,
  output logic            irq_out,
  output logic            irq_oe,
  // Line driver control
  output logic            line_drv_hiz
);

  localparam int SW = 24;

  logic [SW-1:0] sync_w;
  logic          s_rst_n;
  logic          s_host_sel;
  logic          s_style;
  logic          s_cs_n;
  logic          s_ds_n;
  logic          s_sin;
  logic          s_sclk;
  logic          s_oes;
  logic [7:0]    s_addr;
  logic [7:0]    s_din;

  // All pins pass two flops before use
  hci_sync #(
    .W       (SW),
    .RST_VAL (24'hfd_ffff)   // Idle pin levels; shift clock parks low
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({hw_rst_n, host_sel, bus_style_select, cs_n,
                data_strobe_n, serial_in, sclk, out_edge_select,
                addr, data_in}),
    .sync_out (sync_w)
  );

  assign {s_rst_n, s_host_sel, s_style, s_cs_n,
          s_ds_n, s_sin, s_sclk, s_oes, s_addr, s_din} = sync_w;

  // Reset pin filter
  logic [7:0] rst_cnt_q;
  logic       pin_rst_q;
  logic       rst;

  // Only a low longer than the minimum counts; glitches are ignored
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rst_cnt_q <= 8'h00;
      pin_rst_q <= 1'b0;
    end else if (s_rst_n) begin
      rst_cnt_q <= 8'h00;
      pin_rst_q <= 1'b0;
    end else if (rst_cnt_q >= 8'(`HCI_RST_MIN_CYC)) begin
      pin_rst_q <= 1'b1;
    end else begin
      rst_cnt_q <= rst_cnt_q + 8'h01;
    end
  end

  assign rst = sys_rst | pin_rst_q;

  // Line drivers float for as long as reset lasts
  always_ff @(posedge core_clk) begin
    line_drv_hiz <= rst;
  end

  // Register file
  logic [NSRC-1:0] mask_q;
  logic [NSRC-1:0] stat_q;
  logic [7:0]      gcf_q;
  logic            wr_en;
  logic [7:0]      wr_addr;
  logic [7:0]      wr_data;
  logic [NSRC-1:0] clr;
  logic [7:0]      chan_byte;

  // Read mux, shared by both host interfaces
  function automatic logic [7:0] rd_mux(
    input logic [7:0]  a,
    input logic [15:0] m,
    input logic [15:0] s,
    input logic [7:0]  g,
    input logic [7:0]  c
  );
    logic [7:0] r;
    r = 8'h00;
    if (a == `HCI_OFS_IRQ_MASK_LO) begin
      r = m[7:0];
    end else if (a == `HCI_OFS_IRQ_MASK_HI) begin
      r = m[15:8];
    end else if (a == `HCI_OFS_IRQ_STAT_LO) begin
      r = s[7:0];
    end else if (a == `HCI_OFS_IRQ_STAT_HI) begin
      r = s[15:8];
    end else if (a == `HCI_OFS_GLOBAL_CFG) begin
      r = g;
    end else if (a == `HCI_OFS_CHAN_IRQ) begin
      r = c;
    end
    return r;
  endfunction

  // Clear mask for the status byte just read
  function automatic logic [15:0] rd_clr(
    input logic [7:0] a,
    input logic [7:0] v
  );
    logic [15:0] r;
    r = 16'h0000;
    if (a == `HCI_OFS_IRQ_STAT_LO) begin
      r = {8'h00, v};
    end else if (a == `HCI_OFS_IRQ_STAT_HI) begin
      r = {v, 8'h00};
    end
    return r;
  endfunction

  // Per-channel summary: one bit per channel, any pending source
  genvar c;
  generate
    for (c = 0; c < 8; c++) begin : g_chan
      if (c < NCH) begin : g_on
        assign chan_byte[c] = |stat_q[c*4 +: 4];
      end else begin : g_off
        assign chan_byte[c] = 1'b0;
      end
    end
  endgenerate

  // Writable registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask_q <= {2{`HCI_RST_IRQ_MASK}};
      gcf_q  <= `HCI_RST_GLOBAL_CFG;
    end else if (wr_en) begin
      if (wr_addr == `HCI_OFS_IRQ_MASK_LO) begin
        mask_q[7:0] <= wr_data;
      end else if (wr_addr == `HCI_OFS_IRQ_MASK_HI) begin
        mask_q[15:8] <= wr_data;
      end else if (wr_addr == `HCI_OFS_GLOBAL_CFG) begin
        gcf_q <= wr_data;
      end
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr) | irq_src;
    end
  end

  // Interrupt pin
  logic pend;

  assign pend = (|(stat_q & ~mask_q))
              & ~gcf_q[`HCI_GCF_GMASK_BIT];

  // Pin style; open-drain only ever pulls low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_out <= 1'b0;
      irq_oe  <= 1'b0;
    end else begin
      case (gcf_q[`HCI_GCF_PIN_MSB:`HCI_GCF_PIN_LSB])
        `HCI_PIN_OD_LOW: begin
          irq_out <= 1'b0;
          irq_oe  <= pend;
        end
        `HCI_PIN_PP_LOW: begin
          irq_out <= ~pend;
          irq_oe  <= 1'b1;
        end
        default: begin
          irq_out <= pend;
          irq_oe  <= 1'b1;
        end
      endcase
    end
  end

  // Parallel strobes decoded per bus style
  logic       par_on;
  logic       rd_act;
  logic       wr_act;
  logic       rd_act_q;
  logic       wr_act_q;
  logic [7:0] par_addr_q;
  logic [7:0] par_wdata_q;
  logic       par_wr;
  logic       par_rd_end;

  assign par_on = s_host_sel & ~s_cs_n;
  assign rd_act = s_style ? ~s_ds_n
                          : (~s_ds_n & s_sin);
  assign wr_act = s_style ? ~s_sin
                          : (~s_ds_n & ~s_sin);

  // Address and data follow the strobe; last value before its rise wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_act_q    <= 1'b0;
      wr_act_q    <= 1'b0;
      par_addr_q  <= 8'h00;
      par_wdata_q <= 8'h00;
    end else begin
      rd_act_q <= rd_act & par_on;
      wr_act_q <= wr_act & par_on;
      if (par_on & (wr_act | rd_act)) begin
        par_addr_q  <= s_addr;
        par_wdata_q <= s_din;
      end
    end
  end

  assign par_wr     = wr_act_q & ~wr_act & par_on;
  assign par_rd_end = rd_act_q & ~(rd_act & par_on);

  // Data bus drive; floats outside a selected read
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end else begin
      data_oe <= par_on & rd_act;
      if (par_on & rd_act) begin
        data_out <= rd_mux(s_addr, mask_q, stat_q,
                           gcf_q, chan_byte);
      end
    end
  end

  // Serial frame
  hci_pkg::hci_ser_state_t ser_st_q;
  logic [4:0] ser_cnt_q;
  logic [7:0] cmd_sr_q;
  logic [7:0] ser_sr_q;
  logic [7:0] out_sr_q;
  logic       ser_rd_q;
  logic [7:0] ser_addr_q;
  logic       sclk_d_q;
  logic       ser_on;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       out_edge;
  logic       cmd_end;
  logic       data_end;
  logic       ser_load;
  logic [7:0] ser_cmd_addr;
  logic [7:0] ser_rdata;

  assign ser_on       = ~s_host_sel & ~s_cs_n;
  assign sclk_rise    = s_sclk & ~sclk_d_q;
  assign sclk_fall    = ~s_sclk & sclk_d_q;
  assign out_edge     = s_oes ? sclk_fall : sclk_rise;
  assign cmd_end      = ser_on & sclk_rise
                      & (ser_st_q == hci_pkg::HCI_SER_CMD)
                      & (ser_cnt_q == `HCI_SER_CMD_LAST);
  assign data_end     = ser_on & sclk_rise
                      & (ser_st_q == hci_pkg::HCI_SER_DATA)
                      & (ser_cnt_q == `HCI_SER_DATA_LAST);
  assign ser_cmd_addr = {cmd_sr_q[6:0], s_sin};
  assign ser_load     = cmd_end & cmd_sr_q[7];
  assign ser_rdata    = rd_mux(ser_cmd_addr, mask_q, stat_q,
                               gcf_q, chan_byte);

  // Shift clock edge history
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_d_q <= 1'b0;
    end else begin
      sclk_d_q <= s_sclk;
    end
  end

  // Frame sequencer; chip select high always restarts the frame
  always_ff @(posedge core_clk) begin
    if (rst || !ser_on) begin
      ser_st_q   <= hci_pkg::HCI_SER_CMD;
      ser_cnt_q  <= 5'h00;
      cmd_sr_q   <= 8'h00;
      ser_sr_q   <= 8'h00;
      ser_rd_q   <= 1'b0;
      ser_addr_q <= 8'h00;
    end else if (sclk_rise) begin
      case (ser_st_q)
        hci_pkg::HCI_SER_CMD: begin
          cmd_sr_q  <= {cmd_sr_q[6:0], s_sin};
          ser_cnt_q <= ser_cnt_q + 5'h01;
          if (cmd_end) begin
            ser_st_q   <= hci_pkg::HCI_SER_DATA;
            ser_cnt_q  <= 5'h00;
            ser_rd_q   <= cmd_sr_q[7];
            ser_addr_q <= ser_cmd_addr;
          end
        end
        hci_pkg::HCI_SER_DATA: begin
          ser_sr_q  <= {ser_sr_q[6:0], s_sin};
          ser_cnt_q <= ser_cnt_q + 5'h01;
          if (data_end) begin
            ser_st_q <= hci_pkg::HCI_SER_DONE;
          end
        end
        default: begin
          ser_st_q <= hci_pkg::HCI_SER_DONE;
        end
      endcase
    end
  end

  // Read data leaves MSB first on the selected edge
  always_ff @(posedge core_clk) begin
    if (rst || !ser_on) begin
      out_sr_q   <= 8'h00;
      serial_out <= 1'b0;
    end else if (ser_load && !s_oes) begin
      serial_out <= ser_rdata[7];
      out_sr_q   <= {ser_rdata[6:0], 1'b0};
    end else if (ser_load) begin
      out_sr_q <= ser_rdata;
    end else if (out_edge && ser_rd_q
                 && ser_st_q == hci_pkg::HCI_SER_DATA) begin
      serial_out <= out_sr_q[7];
      out_sr_q   <= {out_sr_q[6:0], 1'b0};
    end
  end

  // Output floats whenever the serial port is not selected
  always_ff @(posedge core_clk) begin
    if (rst) begin
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= ser_on;
    end
  end

  // Merge both hosts onto one write port and one clear port
  always_comb begin
    wr_en   = 1'b0;
    wr_addr = par_addr_q;
    wr_data = par_wdata_q;
    clr     = '0;
    if (par_wr) begin
      wr_en = 1'b1;
    end else if (data_end && !ser_rd_q) begin
      wr_en   = 1'b1;
      wr_addr = ser_addr_q;
      wr_data = {ser_sr_q[6:0], s_sin};
    end
    if (par_rd_end) begin
      clr = rd_clr(par_addr_q, data_out);
    end else if (ser_load) begin
      clr = rd_clr(ser_cmd_addr, ser_rdata);
    end
  end

endmodule

`default_nettype wire

/* tb_top.sv */
// Self-checking bench: host model, control port and checker.
// Assumes the design files and the two files above compile first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // Pins and bench state
  logic        core_clk, sys_rst, hw_rst_n, host_sel, bus_style_select;
  logic        cs_n, data_strobe_n, serial_in, sclk, out_edge_select;
  logic        data_oe, serial_out, serial_out_oe, irq_out, irq_oe;
  logic        line_drv_hiz;
  logic [15:0] irq_src;
  logic [7:0]  addr, data_in, data_out, rv, pin_w;
  int          bad_count, num_checks, cycles;
  assign pin_w = {6'h0, irq_out, irq_oe};
  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;
  // Hang guard, far above the roughly 1400 cycles needed
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end
  hci_top hci_top_inst (.*);
  hci_host_model hci_host_model_inst (.*);
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pw(input logic s, input logic [7:0] a, input logic [7:0] d);
    hci_host_model_inst.par_acc(s, 1'b1, a, d, rv);
  endtask
  task automatic pr(input logic s, input logic [7:0] a, input logic [7:0] e);
    hci_host_model_inst.par_acc(s, 1'b0, a, 8'h00, rv);
    chk(rv, e);
  endtask
  task automatic pulse(input logic [15:0] m);
    irq_src <= m;
    @(posedge core_clk);
    irq_src <= 16'h0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic t_defaults();
    pr(1'b0, 8'h11, 8'hff);
    pr(1'b1, 8'h12, 8'hff);
    pr(1'b0, 8'h40, 8'h04);
    pr(1'b1, 8'h16, 8'h00);
    pr(1'b0, 8'h80, 8'h00);
  endtask
  // Both strobe styles, unmapped and read-only places
  task automatic t_rw();
    pw(1'b0, 8'h11, 8'h5a);
    pr(1'b1, 8'h11, 8'h5a);
    pw(1'b1, 8'h12, 8'ha5);
    pr(1'b0, 8'h12, 8'ha5);
    pw(1'b1, 8'h55, 8'h3c);
    pr(1'b0, 8'h55, 8'h00);
    pw(1'b0, 8'h16, 8'hff);
    pr(1'b1, 8'h16, 8'h00);
  endtask
  task automatic t_serial();
    for (int k = 0; k < 2; k++) begin
      hci_host_model_inst.ser_acc(k[0], 1'b0, 8'h12, 8'hc5 ^ k[7:0], rv);
      hci_host_model_inst.ser_acc(k[0], 1'b1, 8'h12, 8'h00, rv);
      chk(rv, 8'hc5 ^ k[7:0]);
    end
    pr(1'b0, 8'h12, 8'hc4);
  endtask
  // Pin styles, per-source and global masks, read clearing
  task automatic t_irq();
    logic [7:0] pend [3];
    logic [7:0] idle [3];
    pend = '{8'h01, 8'h01, 8'h03};
    idle = '{8'h00, 8'h03, 8'h01};
    pw(1'b0, 8'h11, 8'hfe);
    for (int s = 0; s < 3; s++) begin
      pw(1'b1, 8'h40, s[7:0]);
      chk(pin_w, idle[s]);
      pulse(16'h0001);
      chk(pin_w, pend[s]);
      pr(1'b0, 8'h16, 8'h01);
    end
    pulse(16'h0400);
    chk(pin_w, idle[2]);
    pr(1'b1, 8'h80, 8'h04);
    pr(1'b0, 8'h17, 8'h04);
    pw(1'b1, 8'h40, 8'h06);
    pulse(16'h0001);
    chk(pin_w, idle[2]);
    pr(1'b0, 8'h16, 8'h01);
  endtask
  task automatic t_hwrst();
    pw(1'b0, 8'h11, 8'h00);
    hw_rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    hw_rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    pr(1'b1, 8'h11, 8'h00);
    hw_rst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    chk({7'h0, line_drv_hiz}, 8'h01);
    hw_rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk({7'h0, line_drv_hiz}, 8'h00);
    pr(1'b1, 8'h11, 8'hff);
    pr(1'b0, 8'h40, 8'h04);
  endtask
  initial begin
    sys_rst = 1'b1;
    hw_rst_n = 1'b1;
    irq_src = 16'h0;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    t_defaults();
    t_rw();
    t_serial();
    t_irq();
    t_hwrst();
    final_report();
  end
endmodule
bind hci_top hci_asserts #(.NSRC(NSRC)) hci_asserts_inst (.*);
`default_nettype wire
